// >>> rtl/xlat_pkg.sv
// Constants and types shared by the symbol coder
package xlat_pkg;

    localparam logic [7:0] XLAT_PAGE          = 8'h02;
    localparam logic [7:0] XLAT_DATA_LOW_ADDR = 8'hC2;
    localparam logic [7:0] XLAT_DATA_MID_ADDR = 8'hC3;
    localparam logic [7:0] XLAT_DATA_HI_ADDR  = 8'hC4;
    localparam logic [7:0] XLAT_CONTROL_ADDR  = 8'hC5;

    localparam int CTL_READY_BIT  = 7;
    localparam int CTL_ERROR_BIT  = 6;
    localparam int CTL_ENCODE_BIT = 5;
    localparam int CTL_DECODE_BIT = 4;
    localparam int CTL_DMA_BIT    = 2;
    localparam int CTL_ENDIAN_BIT = 1;
    localparam int CTL_MODE_BIT   = 0;

    localparam logic [7:0] DATA_RESET    = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;

    // Bytes in and out per block
    localparam logic [1:0] MAN_ENC_IN  = 2'h1;
    localparam logic [1:0] MAN_ENC_OUT = 2'h2;
    localparam logic [1:0] MAN_DEC_IN  = 2'h2;
    localparam logic [1:0] MAN_DEC_OUT = 2'h1;
    localparam logic [1:0] TOS_ENC_IN  = 2'h2;
    localparam logic [1:0] TOS_ENC_OUT = 2'h3;
    localparam logic [1:0] TOS_DEC_IN  = 2'h3;
    localparam logic [1:0] TOS_DEC_OUT = 2'h2;

    localparam int BUF_DEPTH = 2;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'h1,
        ST_CALC   = 4'h2,
        ST_EMIT   = 4'h4,
        ST_GATHER = 4'h8
    } xlat_state_e;

endpackage

// >>> rtl/xlat_symbol_core.sv
// Combinational Manchester and three-out-of-six translator for one block
module xlat_symbol_core
    import xlat_pkg::*;
(
    input  wire logic        mode_i,
    input  wire logic        encode_i,
    input  wire logic [23:0] din_i,
    output logic      [23:0] dout_o,
    output logic             err_o
);

    function automatic logic [7:0] man_enc(input logic [3:0] n);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 4; i++)
        begin
            r[2*i +: 2] = n[i] ? 2'h1 : 2'h2;
        end
        return r;
    endfunction

    // Bit 4 of the result flags an invalid byte
    function automatic logic [4:0] man_dec(input logic [7:0] b);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < 4; i++)
        begin
            case (b[2*i +: 2])
                2'h1:    r[i] = 1'b1;
                2'h2:    r[i] = 1'b0;
                default: r[4] = 1'b1;
            endcase
        end
        return r;
    endfunction

    function automatic logic [5:0] tos_enc(input logic [3:0] n);
        case (n)
            4'h0:    return 6'h16;
            4'h1:    return 6'h0D;
            4'h2:    return 6'h0E;
            4'h3:    return 6'h0B;
            4'h4:    return 6'h1C;
            4'h5:    return 6'h19;
            4'h6:    return 6'h1A;
            4'h7:    return 6'h13;
            4'h8:    return 6'h2C;
            4'h9:    return 6'h25;
            4'hA:    return 6'h26;
            4'hB:    return 6'h23;
            4'hC:    return 6'h34;
            4'hD:    return 6'h31;
            4'hE:    return 6'h32;
            default: return 6'h29;
        endcase
    endfunction

    function automatic logic [4:0] tos_dec(input logic [5:0] s);
        case (s)
            6'h16:   return 5'h00;
            6'h0D:   return 5'h01;
            6'h0E:   return 5'h02;
            6'h0B:   return 5'h03;
            6'h1C:   return 5'h04;
            6'h19:   return 5'h05;
            6'h1A:   return 5'h06;
            6'h13:   return 5'h07;
            6'h2C:   return 5'h08;
            6'h25:   return 5'h09;
            6'h26:   return 5'h0A;
            6'h23:   return 5'h0B;
            6'h34:   return 5'h0C;
            6'h31:   return 5'h0D;
            6'h32:   return 5'h0E;
            6'h29:   return 5'h0F;
            default: return 5'h10;
        endcase
    endfunction

    always_comb
    begin
        logic [4:0] d0;
        logic [4:0] d1;
        logic [4:0] t0;
        logic [4:0] t1;
        logic [4:0] t2;
        logic [4:0] t3;
        d0 = man_dec(din_i[7:0]);
        d1 = man_dec(din_i[15:8]);
        t0 = tos_dec(din_i[5:0]);
        t1 = tos_dec(din_i[11:6]);
        t2 = tos_dec(din_i[17:12]);
        t3 = tos_dec(din_i[23:18]);
        dout_o = 24'h000000;
        err_o  = 1'b0;
        case ({mode_i, encode_i})
            2'h1: dout_o = {8'h00, man_enc(din_i[7:4]), man_enc(din_i[3:0])};              // [R21] [R24]
            2'h0:
            begin
                err_o = d0[4] | d1[4];                                                    // [R22]
                dout_o = err_o ? 24'h00FFFF : {16'h0000, d1[3:0], d0[3:0]};               // [R22] [R24]
            end
            2'h3: dout_o = {tos_enc(din_i[15:12]), tos_enc(din_i[11:8]),
                            tos_enc(din_i[7:4]), tos_enc(din_i[3:0])};                    // [R23]
            default:
            begin
                err_o = t0[4] | t1[4] | t2[4] | t3[4];                                    // [R23]
                dout_o = err_o ? 24'h00FFFF : {8'h00, t3[3:0], t2[3:0], t1[3:0], t0[3:0]};
            end
        endcase
    end

endmodule

// >>> rtl/xlat_coder.sv
// Symbol coder: register page, operation sequencer and DMA byte paths
// Function
// R1: Writing one to control bit 5 starts an encode.
// R2: Writing one to control bit 4 starts a decode.
// R3: Control bit 0 picks Manchester (0) or three-out-of-six (1).
// R4: Ready flag, control bit 7, sets when an operation completes.
// R5: Error flag, control bit 6, sets on a decode failure.
// R6: Software clears ready and error each operation; hardware leaves them set.
// R7: Register use: clear control, write data, start, poll ready, read results.
// R8: Register decode uses control values 0x10 or 0x11.
// R9: Register encode uses control values 0x20 or 0x21.
// R10: DMA decode uses control values 0x16 or 0x17.
// R11: DMA encode uses control values 0x26 or 0x27.
// R12: Control bit 2 selects DMA operation.
// R13: Control bit 1 selects big-endian byte order on DMA transfers.
// R14: DMA decoding continues after an error; error stays set for the transfer.
// R15: A decode error can request an interrupt, enabled outside the block.
// R16: Error handler may stall then disable DMA channels to abort.
// R17: Input DMA channel set up with request code 0x00, big-endian.
// R18: Output DMA channel set up with request code 0x01, big-endian.
// R19: Software waits for DMA interrupt, then checks error after decode.
// R20: All four registers sit on page 0x2; control is not bit-addressable.
// R21: Manchester encode maps each nibble to one byte, high nibble to middle.
// R22: Invalid Manchester input sets error and gives all-ones output.
// R23: Three-out-of-six maps nibbles to six-bit symbols, and back.
// R24: Data stays right-justified; high byte unused in Manchester mode.
// R25: Start bits self-clear; results replace input before ready sets.
// R26: Control bit 3 reads zero and ignores writes.
module xlat_coder
    import xlat_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    input  wire logic [7:0] sfr_page_i,
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic       sfr_wr_i,
    input  wire logic       sfr_rd_i,
    input  wire logic [7:0] sfr_wdata_i,
    output logic      [7:0] sfr_rdata_o,
    input  wire logic       dma_in_valid_i,
    input  wire logic [7:0] dma_in_data_i,
    output logic            dma_in_ready_o,
    output logic            dma_out_valid_o,
    output logic      [7:0] dma_out_data_o,
    input  wire logic       dma_out_ready_i,
    output logic            ready_o,
    output logic            decode_err_irq_o
);

    typedef struct packed {
        xlat_state_e          st;
        logic                 ready;
        logic                 error;
        logic                 symbolize_go;
        logic                 dec;
        logic                 dma;
        logic                 endian;
        logic                 mode;
        logic                 op_enc;
        logic [2:0][7:0]      dat;
        logic [1:0]           cnt;
        logic [7:0]           rdata;
        logic [1:0][7:0]      fifo;
        logic                 wp;
        logic                 rp;
        logic [1:0]           fill;
    } coder_s;

    coder_s st_r;
    coder_s st_nxt;

    logic [23:0] core_out;
    logic        core_err;

    function automatic logic [1:0] bytes_in(input logic mode, input logic symbolize_go);
        case ({mode, symbolize_go})
            2'h1:    return MAN_ENC_IN;
            2'h0:    return MAN_DEC_IN;
            2'h3:    return TOS_ENC_IN;
            default: return TOS_DEC_IN;
        endcase
    endfunction

    function automatic logic [1:0] bytes_out(input logic mode, input logic symbolize_go);
        case ({mode, symbolize_go})
            2'h1:    return MAN_ENC_OUT;
            2'h0:    return MAN_DEC_OUT;
            2'h3:    return TOS_ENC_OUT;
            default: return TOS_DEC_OUT;
        endcase
    endfunction

    function automatic logic [7:0] control_image(input coder_s s);
        logic [7:0] v;
        v = 8'h00;
        v[CTL_READY_BIT]  = s.ready;
        v[CTL_ERROR_BIT]  = s.error;
        v[CTL_ENCODE_BIT] = s.symbolize_go;
        v[CTL_DECODE_BIT] = s.dec;
        v[CTL_DMA_BIT]    = s.dma;
        v[CTL_ENDIAN_BIT] = s.endian;
        v[CTL_MODE_BIT]   = s.mode;
        return v;                                                                  // [R26]
    endfunction

    xlat_symbol_core u_core (
        .mode_i   (st_r.mode),
        .encode_i (st_r.op_enc),
        .din_i    (st_r.dat),
        .dout_o   (core_out),
        .err_o    (core_err)
    );

    always_comb
    begin
        logic       page_hit;
        logic       wr_ctl;
        logic       start;
        logic       push;
        logic       pop;
        logic       set_ready;
        logic       set_error;
        logic [1:0] idx;
        logic [1:0] nin;
        logic [1:0] nout;
        st_nxt    = st_r;
        page_hit  = (sfr_page_i == XLAT_PAGE);                                     // [R20]
        wr_ctl    = sfr_wr_i && page_hit && (sfr_addr_i == XLAT_CONTROL_ADDR);
        start     = wr_ctl && (sfr_wdata_i[CTL_ENCODE_BIT] || sfr_wdata_i[CTL_DECODE_BIT]);
        push      = 1'b0;
        set_ready = 1'b0;
        set_error = 1'b0;
        idx       = 2'h0;
        nin       = bytes_in(st_r.mode, st_r.op_enc);
        nout      = bytes_out(st_r.mode, st_r.op_enc);
        pop       = (st_r.fill != 2'h0) && dma_out_ready_i;

        // Reads answer one cycle later from a flop
        st_nxt.rdata = 8'h00;
        if (sfr_rd_i && page_hit)
        begin
            case (sfr_addr_i)
                XLAT_DATA_LOW_ADDR: st_nxt.rdata = st_r.dat[0];
                XLAT_DATA_MID_ADDR: st_nxt.rdata = st_r.dat[1];
                XLAT_DATA_HI_ADDR:  st_nxt.rdata = st_r.dat[2];
                XLAT_CONTROL_ADDR:  st_nxt.rdata = control_image(st_r);
                default:            st_nxt.rdata = 8'h00;
            endcase
        end

        // Software data writes; the sequencer overrides them below
        if (sfr_wr_i && page_hit)
        begin
            case (sfr_addr_i)
                XLAT_DATA_LOW_ADDR: st_nxt.dat[0] = sfr_wdata_i;
                XLAT_DATA_MID_ADDR: st_nxt.dat[1] = sfr_wdata_i;
                XLAT_DATA_HI_ADDR:  st_nxt.dat[2] = sfr_wdata_i;
                default:            st_nxt.dat = st_r.dat;
            endcase
        end

        case (st_r.st)
            ST_IDLE:
            begin
                st_nxt.st = ST_IDLE;
            end
            ST_CALC:
            begin
                st_nxt.dat = core_out;                                             // [R25]
                set_ready  = 1'b1;                                                 // [R4]
                set_error  = core_err && !st_r.op_enc;                             // [R5] [R14]
                st_nxt.cnt = 2'h0;
                st_nxt.st  = st_r.dma ? ST_EMIT : ST_IDLE;                         // [R12]
            end
            ST_EMIT:
            begin
                // Stall while the output buffer is full and no byte leaves it
                if (st_r.fill != 2'(BUF_DEPTH) || pop)
                begin
                    push = 1'b1;
                    idx  = st_r.endian ? 2'(nout - 2'h1 - st_r.cnt) : st_r.cnt;    // [R13]
                    st_nxt.cnt = st_r.cnt + 2'h1;
                    if (st_r.cnt == nout - 2'h1)
                    begin
                        st_nxt.cnt = 2'h0;
                        st_nxt.dat = 24'h000000;
                        st_nxt.st  = ST_GATHER;                                    // [R14]
                    end
                end
            end
            ST_GATHER:
            begin
                if (dma_in_valid_i)
                begin
                    if (st_r.endian)
                    begin
                        st_nxt.dat = {st_r.dat[1], st_r.dat[0], dma_in_data_i};   // [R13]
                    end
                    else
                    begin
                        st_nxt.dat[st_r.cnt] = dma_in_data_i;
                    end
                    st_nxt.cnt = st_r.cnt + 2'h1;
                    if (st_r.cnt == nin - 2'h1)
                    begin
                        st_nxt.st = ST_CALC;
                    end
                end
            end
            default:
            begin
                st_nxt.st = ST_IDLE;
            end
        endcase

        // Control write; bits 7 and 6 only clear, so a late set still wins
        if (wr_ctl)
        begin
            st_nxt.ready  = st_r.ready & sfr_wdata_i[CTL_READY_BIT];               // [R6]
            st_nxt.error  = st_r.error & sfr_wdata_i[CTL_ERROR_BIT];               // [R6]
            st_nxt.dma    = sfr_wdata_i[CTL_DMA_BIT];                              // [R12]
            st_nxt.endian = sfr_wdata_i[CTL_ENDIAN_BIT];                           // [R13]
            st_nxt.mode   = sfr_wdata_i[CTL_MODE_BIT];                             // [R3]
            st_nxt.symbolize_go    = sfr_wdata_i[CTL_ENCODE_BIT];                           // [R1]
            st_nxt.dec    = sfr_wdata_i[CTL_DECODE_BIT];                           // [R2]
            if (!sfr_wdata_i[CTL_DMA_BIT] && st_r.st != ST_CALC)
            begin
                // Leaving DMA use drops any half-gathered block
                st_nxt.st  = ST_IDLE;
                st_nxt.cnt = 2'h0;
            end
        end
        if (start && st_r.st == ST_IDLE)
        begin
            st_nxt.op_enc = sfr_wdata_i[CTL_ENCODE_BIT];                           // [R1] [R2]
            st_nxt.cnt    = 2'h0;
            if (sfr_wdata_i[CTL_DMA_BIT])
            begin
                st_nxt.dat = 24'h000000;
                st_nxt.st  = ST_GATHER;                                            // [R12]
            end
            else
            begin
                st_nxt.st = ST_CALC;
            end
        end
        if (st_r.symbolize_go || st_r.dec)
        begin
            st_nxt.symbolize_go = 1'b0;                                                     // [R25]
            st_nxt.dec = 1'b0;                                                     // [R25]
        end
        if (set_ready)
        begin
            st_nxt.ready = 1'b1;                                                   // [R4]
        end
        if (set_error)
        begin
            st_nxt.error = 1'b1;                                                   // [R5] [R14]
        end

        // Two-entry output buffer so a stalled receiver loses no byte
        if (push)
        begin
            st_nxt.fifo[st_r.wp] = st_r.dat[idx];
            st_nxt.wp = ~st_r.wp;
        end
        if (pop)
        begin
            st_nxt.rp = ~st_r.rp;
        end
        st_nxt.fill = st_r.fill + (push ? 2'h1 : 2'h0) - (pop ? 2'h1 : 2'h0);
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_r        <= '0;
            st_r.st     <= ST_IDLE;
            st_r.dat    <= {DATA_RESET, DATA_RESET, DATA_RESET};
            st_r.ready  <= CONTROL_RESET[CTL_READY_BIT];
            st_r.error  <= CONTROL_RESET[CTL_ERROR_BIT];
            st_r.symbolize_go    <= CONTROL_RESET[CTL_ENCODE_BIT];
            st_r.dec    <= CONTROL_RESET[CTL_DECODE_BIT];
            st_r.dma    <= CONTROL_RESET[CTL_DMA_BIT];
            st_r.endian <= CONTROL_RESET[CTL_ENDIAN_BIT];
            st_r.mode   <= CONTROL_RESET[CTL_MODE_BIT];
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign sfr_rdata_o      = st_r.rdata;
    assign dma_in_ready_o   = (st_r.st == ST_GATHER);
    assign dma_out_valid_o  = (st_r.fill != 2'h0);
    assign dma_out_data_o   = st_r.fifo[st_r.rp];
    assign ready_o          = st_r.ready;
    assign decode_err_irq_o = st_r.error;                                          // [R15]

endmodule

// >>> verification/xlat_checker.sv
// Port-level assertions for the symbol coder
module xlat_checker
    import xlat_pkg::*;
(
    input wire logic       sys_clk_i,
    input wire logic       rst_i,
    input wire logic [7:0] sfr_page_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic       sfr_wr_i,
    input wire logic       sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic       dma_in_valid_i,
    input wire logic [7:0] dma_in_data_i,
    input wire logic       dma_in_ready_o,
    input wire logic       dma_out_valid_o,
    input wire logic [7:0] dma_out_data_o,
    input wire logic       dma_out_ready_i,
    input wire logic       ready_o,
    input wire logic       decode_err_irq_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic ctl_wr;
    logic ctl_rd;
    assign ctl_wr = sfr_wr_i && sfr_page_i == XLAT_PAGE && sfr_addr_i == XLAT_CONTROL_ADDR;
    assign ctl_rd = sfr_rd_i && sfr_page_i == XLAT_PAGE && sfr_addr_i == XLAT_CONTROL_ADDR;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // Only honoured from idle: the bench always clears control before a start
    sequence s_reg_start;
        ctl_wr && (sfr_wdata_i[CTL_ENCODE_BIT] || sfr_wdata_i[CTL_DECODE_BIT])
            && !sfr_wdata_i[CTL_DMA_BIT] && sfr_wdata_i[7:6] == 2'h0;
    endsequence
    sequence s_reg_done;
        !ready_o ##1 ready_o;
    endsequence
    a_start_to_ready: assert property (s_reg_start |=> s_reg_done)
        else $error("ready not seen two cycles after start");
    a_encode_no_error: assert property (s_reg_start ##0 sfr_wdata_i[CTL_ENCODE_BIT] |=> ##1 !decode_err_irq_o)
        else $error("error flag raised by an encode");
    a_ready_sticky: assert property (ready_o && !(ctl_wr && !sfr_wdata_i[7]) |=> ready_o)
        else $error("ready dropped without software clear");
    a_error_sticky: assert property (decode_err_irq_o && !(ctl_wr && !sfr_wdata_i[6]) |=> decode_err_irq_o)
        else $error("error dropped without software clear");
    a_ctl_readback: assert property (ctl_rd |=> sfr_rdata_o[7] == $past(ready_o)
        && sfr_rdata_o[6] == $past(decode_err_irq_o) && !sfr_rdata_o[3])
        else $error("control read disagrees with flags");
    a_foreign_page: assert property (sfr_rd_i && sfr_page_i != XLAT_PAGE |=> sfr_rdata_o == 8'h00)
        else $error("read answered on another page");
    a_rdata_rest: assert property (!sfr_rd_i |=> sfr_rdata_o == 8'h00)
        else $error("read data outstays its cycle");
    a_out_hold: assert property (dma_out_valid_o && !dma_out_ready_i |=> dma_out_valid_o && $stable(dma_out_data_o))
        else $error("output byte changed while stalled");
    a_idle_refuses: assert property (ctl_wr && !sfr_wdata_i[CTL_DMA_BIT] |=> !dma_in_ready_o)
        else $error("input accepted outside transfer mode");
endmodule

bind xlat_coder xlat_checker xlat_checker_inst (.sys_clk_i, .rst_i, .sfr_page_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i,
    .sfr_wdata_i, .sfr_rdata_o, .dma_in_valid_i, .dma_in_data_i, .dma_in_ready_o, .dma_out_valid_o,
    .dma_out_data_o, .dma_out_ready_i, .ready_o, .decode_err_irq_o);

// >>> verification/dma_model.sv
// Behavioural transfer engine: memory feed into the coder and drain back out
module dma_model (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    input  wire logic       stall_i,
    output logic            in_valid_o,
    output logic      [7:0] in_data_o,
    input  wire logic       in_ready_i,
    input  wire logic       out_valid_i,
    input  wire logic [7:0] out_data_i,
    output logic            out_ready_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] in_q[$];
    logic [7:0] out_q[$];
    always @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            in_valid_o <= 1'b0;
            in_data_o <= 8'h00;
            out_ready_o <= 1'b0;
        end
        else
        begin
            if (in_valid_o && in_ready_i)
                void'(in_q.pop_front());
            if (in_q.size() > 0)
            begin
                in_valid_o <= 1'b1;
                in_data_o <= in_q[0];
            end
            else
            begin
                in_valid_o <= 1'b0;
                // Idle line toggles so a stale byte is never mistaken for data
                in_data_o <= ~in_data_o;
            end
            if (out_valid_i && out_ready_o)
                out_q.push_back(out_data_i);
            out_ready_o <= !stall_i;
        end
    end
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the symbol coder
module tb_top
    import xlat_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst, wr, rd, stall, ivld, irdy, ovld, ordy, rdy, irq;
    logic [7:0] page, addr, wdata, rdata, idat, odat, v, pg;
    logic [23:0] d;
    logic [24:0] x;
    int seed = 24530;
    int miscompares = 0;
    int checks = 0;
    logic [5:0] tos [16] = '{6'h16, 6'h0D, 6'h0E, 6'h0B, 6'h1C, 6'h19, 6'h1A, 6'h13,
                             6'h2C, 6'h25, 6'h26, 6'h23, 6'h34, 6'h31, 6'h32, 6'h29};
    logic [7:0] ops [5] = '{8'h26, 8'h24, 8'h27, 8'h16, 8'h17};
    xlat_coder xlat_coder_inst (.sys_clk_i(clk), .rst_i(rst), .sfr_page_i(page), .sfr_addr_i(addr),
        .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .dma_in_valid_i(ivld),
        .dma_in_data_i(idat), .dma_in_ready_o(irdy), .dma_out_valid_o(ovld), .dma_out_data_o(odat),
        .dma_out_ready_i(ordy), .ready_o(rdy), .decode_err_irq_o(irq));
    dma_model dma_model_inst (.sys_clk_i(clk), .rst_i(rst), .stall_i(stall), .in_valid_o(ivld),
        .in_data_o(idat), .in_ready_i(irdy), .out_valid_i(ovld), .out_data_i(odat), .out_ready_o(ordy));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk)
        stall <= $random(seed) % 2 != 0;
    function automatic logic [7:0] man_e(input logic [3:0] n);
        logic [7:0] r;
        for (int i = 0; i < 4; i++)
            r[2*i+:2] = {~n[i], n[i]};
        return r;
    endfunction
    // Expected {error, data} of one block
    function automatic logic [24:0] calc(input logic m, input logic e, input logic [23:0] din);
        logic [24:0] r;
        logic ok, bad;
        r = 25'h0;
        bad = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            ok = 1'b0;
            if (e && m)
                r[6*i+:6] = tos[din[4*i+:4]];
            else if (e && i < 2)
                r[8*i+:8] = man_e(din[4*i+:4]);
            for (int k = 0; k < 16; k++)
                if (!e && (m ? tos[k] == din[6*i+:6] : i < 2 && man_e(k[3:0]) == din[8*i+:8]))
                begin
                    ok = 1'b1;
                    r[4*i+:4] = k[3:0];
                end
            if (!e && !ok && (m || i < 2))
                bad = 1'b1;
        end
        return bad ? {1'b1, 24'h00FFFF} : r;
    endfunction
    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] dv);
        @(posedge clk);
        page <= pg;
        addr <= a;
        wdata <= dv;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, output logic [7:0] dv);
        @(posedge clk);
        page <= pg;
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 dv = rdata;
    endtask
    task automatic wait_for(input int lim, input int want);
        int n;
        n = 0;
        while (!(want < 0 ? rdy === 1'b1 : dma_model_inst.out_q.size() >= want) && n < lim)
        begin
            @(posedge clk);
            n++;
        end
        if (n == lim)
        begin
            miscompares++;
            $display("unexpected at %0t: wait ran out", $time);
            report_and_stop();
        end
    endtask
    task automatic reg_op(input logic [7:0] ctl, input logic [23:0] din);
        logic [24:0] r;
        r = calc(ctl[0], ctl[5], din);
        wreg(XLAT_CONTROL_ADDR, 8'h00);
        wreg(XLAT_DATA_LOW_ADDR, din[7:0]);
        wreg(XLAT_DATA_MID_ADDR, din[15:8]);
        wreg(XLAT_DATA_HI_ADDR, din[23:16]);
        wreg(XLAT_CONTROL_ADDR, ctl);
        wait_for(50, -1);
        for (int i = 0; i < 3; i++)
        begin
            rreg(XLAT_DATA_LOW_ADDR + 8'(i), v);
            chk(v, r[8*i+:8]);
        end
        rreg(XLAT_CONTROL_ADDR, v);
        chk(v, {1'b1, r[24], 5'h00, ctl[0]});
        chk({7'h0, irq}, {7'h0, r[24]});
    endtask
    task automatic dma_run(input logic [7:0] ctl, input int nb);
        logic [7:0] q[$];
        logic [24:0] r;
        logic [23:0] dd;
        logic acc;
        int ni, no;
        ni = ctl[0] ? (ctl[5] ? TOS_ENC_IN : TOS_DEC_IN) : (ctl[5] ? MAN_ENC_IN : MAN_DEC_IN);
        no = ctl[0] ? (ctl[5] ? TOS_ENC_OUT : TOS_DEC_OUT) : (ctl[5] ? MAN_ENC_OUT : MAN_DEC_OUT);
        acc = 1'b0;
        for (int b = 0; b < nb; b++)
        begin
            dd = $random(seed);
            r = calc(ctl[0], 1'b1, dd);
            if (!ctl[5])
                dd = b == 1 ? 24'h0 : r[23:0];
            r = calc(ctl[0], ctl[5], dd);
            acc = acc | r[24];
            for (int i = 0; i < ni; i++)
                dma_model_inst.in_q.push_back(dd[8*(ctl[1] ? ni-1-i : i)+:8]);
            for (int i = 0; i < no; i++)
                q.push_back(r[8*(ctl[1] ? no-1-i : i)+:8]);
        end
        wreg(XLAT_CONTROL_ADDR, 8'h00);
        wreg(XLAT_CONTROL_ADDR, ctl);
        wait_for(3000, q.size());
        foreach (q[i])
            chk(dma_model_inst.out_q[i], q[i]);
        chk({7'h0, irq}, {7'h0, acc});
        wreg(XLAT_CONTROL_ADDR, 8'h00);
        dma_model_inst.out_q.delete();
        $display("test dma %h done", ctl);
    endtask
    initial
    begin
        {page, addr, wr, rd, wdata} = '0;
        pg = XLAT_PAGE;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int a = 8'hC2; a <= 8'hC6; a++)
        begin
            rreg(a[7:0], v);
            chk(v, 8'h00);
        end
        pg = 8'h00;
        wreg(XLAT_DATA_LOW_ADDR, 8'hA5);
        rreg(XLAT_DATA_LOW_ADDR, v);
        chk(v, 8'h00);
        pg = XLAT_PAGE;
        rreg(XLAT_DATA_LOW_ADDR, v);
        chk(v, 8'h00);
        wreg(XLAT_CONTROL_ADDR, 8'hC8);
        rreg(XLAT_CONTROL_ADDR, v);
        chk(v, 8'h00);
        $display("test map done");
        reg_op(8'h20, 24'h00000F);
        reg_op(8'h10, 24'h000000);
        reg_op(8'h11, 24'h000000);
        for (int k = 0; k < 8; k++)
        begin
            d = $random(seed) & (k[0] ? 24'h00FFFF : 24'h0000FF);
            x = calc(k[0], 1'b1, d);
            reg_op(8'h20 | 8'(k[0]), d);
            reg_op(8'h10 | 8'(k[0]), x[23:0]);
        end
        $display("test register ops done");
        foreach (ops[i])
            dma_run(ops[i], 3);
        report_and_stop();
    end
endmodule
